// ==== logic/tks_consts.svh ====
`ifndef TKS_CONSTS_SVH
`define TKS_CONSTS_SVH

// ****************************************************************
// Register map: byte offsets on the APB slave.
// ****************************************************************
`define TKS_ADDR_W 12
`define TKS_OFF_SEC 12'h000
`define TKS_OFF_PRE 12'h004
`define TKS_OFF_ALM 12'h008
`define TKS_OFF_COMP 12'h00C
`define TKS_OFF_CTRL 12'h010
`define TKS_OFF_STAT 12'h014
`define TKS_OFF_LOCK 12'h018

// ****************************************************************
// Field positions.
// ****************************************************************
`define TKS_CR_SWR 0
`define TKS_CR_UM 3
`define TKS_SR_TCE 4
`define TKS_SR_TAF 2
`define TKS_SR_TOF 1
`define TKS_SR_TIF 0
`define TKS_LR_LRL 6
`define TKS_LR_SRL 5
`define TKS_LR_CRL 4
`define TKS_LR_TCL 3

// ****************************************************************
// Reset values and counter limits.
// ****************************************************************
`define TKS_LR_FIXED 32'h00000087
`define TKS_SEC_MAX 32'hFFFFFFFF
`define TKS_PRE_CARRY 14
`define TKS_WORD_ZERO 32'h00000000

`endif

// ==== logic/tks_core.sv ====
`include "tks_consts.svh"

module tks_core (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`TKS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Time base pin.
   input wire logic osc_clk
);

   // ****************************************************************
   // Reset value of the whole state.
   // ****************************************************************

   // Time is invalid and every lock is open after power-on.
   localparam tks_pkg::tks_main_s RST = '{
      soft_reset_bit: 1'b0, um: 1'b0, counter_enable_bit: 1'b0, alarm_flag: 1'b0, overflow_flag: 1'b0, time_invalid_flag: 1'b1,
      lock_register_lock: 1'b1, status_register_lock: 1'b1, control_register_lock: 1'b1, compensation_register_lock: 1'b1,
      seconds: 32'h00000000, pre: 16'h0000, alarm: 32'h00000000,
      comp: 32'h00000000, prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0};

   // ****************************************************************
   // Declarations.
   // ****************************************************************

   tks_pkg::tks_main_s s_q;  // Registered state.
   tks_pkg::tks_main_s s_d;  // Next state.
   tks_tick_if tick_bus ();  // Tick from the synchroniser.
   logic acc;                // Access phase that completes at this edge.
   logic wr_sec;             // Completing write to the seconds counter.
   logic wr_pre;             // Completing write to the prescaler.
   logic wr_alm;             // Completing write to the alarm compare.
   logic wr_comp;            // Completing write to the compensation register.
   logic wr_ctl;             // Completing write to the control register.
   logic wr_stat;            // Completing write to the status register.
   logic wr_lock;            // Completing write to the lock register.
   logic step;               // Prescaler advances at this edge.
   logic [15:0] pre_next;    // Prescaler plus one.
   logic sec_inc;            // Seconds counter advances at this edge.
   logic tce_ok;             // Counter enable may be written now.

   // ****************************************************************
   // Time base synchroniser.
   // ****************************************************************

   // The pin crosses three flip-flops, two synchroniser stages and the tick register, before the core sees a tick.
   tks_osc_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .osc_clk(osc_clk),
      .tick_port(tick_bus.src)
   );

   // ****************************************************************
   // Read decoding.
   // ****************************************************************

   // Builds the read word for an offset; unmapped offsets read zero.
   function automatic logic [31:0] read_word(input logic [`TKS_ADDR_W-1:0] a,
                                             input tks_pkg::tks_main_s st);
      logic [31:0] w;
      logic hide;
      w = `TKS_WORD_ZERO;
      hide = st.time_invalid_flag | st.overflow_flag;
      case (a)
         // Counters read zero while time is invalid or overflowed.
         `TKS_OFF_SEC: begin
            w = hide ? `TKS_WORD_ZERO : st.seconds;
         end
         `TKS_OFF_PRE: begin
            w = hide ? `TKS_WORD_ZERO : {16'h0000, st.pre};
         end
         `TKS_OFF_ALM: begin
            w = st.alarm;
         end
         `TKS_OFF_COMP: begin
            w = st.comp;
         end
         `TKS_OFF_CTRL: begin
            w[`TKS_CR_SWR] = st.soft_reset_bit;
            w[`TKS_CR_UM] = st.um;
         end
         `TKS_OFF_STAT: begin
            w[`TKS_SR_TCE] = st.counter_enable_bit;
            w[`TKS_SR_TAF] = st.alarm_flag;
            w[`TKS_SR_TOF] = st.overflow_flag;
            w[`TKS_SR_TIF] = st.time_invalid_flag;
         end
         `TKS_OFF_LOCK: begin
            // Fixed ones in bits 7 and 2 to 0, zeros above.
            w = `TKS_LR_FIXED;
            w[`TKS_LR_LRL] = st.lock_register_lock;
            w[`TKS_LR_SRL] = st.status_register_lock;
            w[`TKS_LR_CRL] = st.control_register_lock;
            w[`TKS_LR_TCL] = st.compensation_register_lock;
         end
         default: begin
            w = `TKS_WORD_ZERO;
         end
      endcase
      return w;
   endfunction

   // ****************************************************************
   // Strobes.
   // ****************************************************************

   // A transfer completes when ready, raised in setup, is seen in access.
   assign acc = psel & penable & s_q.pready;
   assign wr_sec = acc & pwrite & (paddr == `TKS_OFF_SEC);
   assign wr_pre = acc & pwrite & (paddr == `TKS_OFF_PRE);
   assign wr_alm = acc & pwrite & (paddr == `TKS_OFF_ALM);
   assign wr_comp = acc & pwrite & (paddr == `TKS_OFF_COMP);
   assign wr_ctl = acc & pwrite & (paddr == `TKS_OFF_CTRL);
   assign wr_stat = acc & pwrite & (paddr == `TKS_OFF_STAT);
   assign wr_lock = acc & pwrite & (paddr == `TKS_OFF_LOCK);

   // Counting needs enable, valid time, no overflow and a time base edge.
   assign step = tick_bus.tick & s_q.counter_enable_bit & ~s_q.time_invalid_flag & ~s_q.overflow_flag & ~s_q.soft_reset_bit;
   assign pre_next = s_q.pre + 16'h0001;
   // Seconds follow the falling edge of the prescaler carry bit.
   assign sec_inc = step & s_q.pre[`TKS_PRE_CARRY] & ~pre_next[`TKS_PRE_CARRY];
   // Update mode keeps the enable writable in limited conditions.
   assign tce_ok = s_q.status_register_lock | (s_q.um & (s_q.time_invalid_flag | s_q.overflow_flag | ~s_q.counter_enable_bit));

   // ****************************************************************
   // Next state.
   // ****************************************************************

   // One pass fills the next state from bus, tick and current state.
   always_comb begin
      s_d = s_q;
      // Ready is raised for one cycle during every setup phase.
      s_d.pready = psel & ~penable;
      s_d.pslverr = 1'b0;
      if (psel && !penable) begin
         s_d.prdata = read_word(paddr, s_q);
      end
      // Control writes stay possible during soft reset to leave it.
      if (wr_ctl && s_q.control_register_lock) begin
         s_d.soft_reset_bit = pwdata[`TKS_CR_SWR];
         s_d.um = pwdata[`TKS_CR_UM];
      end
      if (s_q.soft_reset_bit) begin
         // Hold everything but the soft reset bit and the control lock.
         s_d.um = RST.um;
         s_d.counter_enable_bit = RST.counter_enable_bit;
         s_d.alarm_flag = RST.alarm_flag;
         s_d.overflow_flag = RST.overflow_flag;
         s_d.time_invalid_flag = RST.time_invalid_flag;
         s_d.lock_register_lock = RST.lock_register_lock;
         s_d.status_register_lock = RST.status_register_lock;
         s_d.compensation_register_lock = RST.compensation_register_lock;
         s_d.seconds = RST.seconds;
         s_d.pre = RST.pre;
         s_d.alarm = RST.alarm;
         s_d.comp = RST.comp;
      end else begin
         // Counter loads are taken only while counting is off.
         if (wr_sec && !s_q.counter_enable_bit) begin
            s_d.seconds = pwdata;
            s_d.overflow_flag = 1'b0;
            s_d.time_invalid_flag = 1'b0;
         end
         if (wr_pre && !s_q.counter_enable_bit) begin
            s_d.pre = pwdata[15:0];
         end
         // Any alarm write clears the flag; a same-cycle match wins below.
         if (wr_alm) begin
            s_d.alarm = pwdata;
            s_d.alarm_flag = 1'b0;
         end
         if (wr_comp && s_q.compensation_register_lock) begin
            s_d.comp = pwdata;
         end
         // Flags in the status word are read only; only enable is stored.
         if (wr_stat && tce_ok) begin
            s_d.counter_enable_bit = pwdata[`TKS_SR_TCE];
         end
         // Lock bits can only be cleared by software.
         if (wr_lock && s_q.lock_register_lock) begin
            s_d.lock_register_lock = s_q.lock_register_lock & pwdata[`TKS_LR_LRL];
            s_d.status_register_lock = s_q.status_register_lock & pwdata[`TKS_LR_SRL];
            s_d.control_register_lock = s_q.control_register_lock & pwdata[`TKS_LR_CRL];
            s_d.compensation_register_lock = s_q.compensation_register_lock & pwdata[`TKS_LR_TCL];
         end
         // Counting, after the writes so that a hardware set wins.
         if (step) begin
            s_d.pre = pre_next;
            if (sec_inc) begin
               if (s_q.seconds == s_q.alarm) begin
                  s_d.alarm_flag = 1'b1;
               end
               if (s_q.seconds == `TKS_SEC_MAX) begin
                  s_d.overflow_flag = 1'b1;
               end
               s_d.seconds = s_q.seconds + 32'h00000001;
            end
         end
      end
   end

   // ****************************************************************
   // State register.
   // ****************************************************************

   // Power-on reset loads constants only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;

   // ****************************************************************
   // Checks.
   // ****************************************************************

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // A seconds write while counting is off.
   sequence s_sec_load;
      wr_sec && !s_q.counter_enable_bit && !s_q.soft_reset_bit;
   endsequence

   // A read setup of a hidden counter.
   sequence s_hidden_read;
      psel && !penable && (paddr == `TKS_OFF_SEC) && (s_q.time_invalid_flag || s_q.overflow_flag);
   endsequence

   // A read setup of the lock register.
   sequence s_lock_read;
      psel && !penable && (paddr == `TKS_OFF_LOCK);
   endsequence

   property p_swr_defaults;
      s_q.soft_reset_bit |=> s_q.time_invalid_flag && (s_q.seconds == 32'h00000000) && s_q.lock_register_lock && !s_q.counter_enable_bit;
   endproperty
   a_swr_defaults: assert property (p_swr_defaults) else $error("reset state missed");

   property p_swr_keep;
      s_q.soft_reset_bit && !(wr_ctl && s_q.control_register_lock && !pwdata[`TKS_CR_SWR]) |=> s_q.soft_reset_bit;
   endproperty
   a_swr_keep: assert property (p_swr_keep) else $error("soft reset bit dropped");

   property p_sec_load;
      s_sec_load |=> s_q.seconds == $past(pwdata);
   endproperty
   a_sec_load: assert property (p_sec_load) else $error("seconds load lost");

   property p_sec_locked;
      wr_sec && s_q.counter_enable_bit && !step && !s_q.soft_reset_bit |=> $stable(s_q.seconds);
   endproperty
   a_sec_locked: assert property (p_sec_locked) else $error("seconds written");

   property p_alarm_set;
      sec_inc && (s_q.seconds == s_q.alarm) |=> s_q.alarm_flag;
   endproperty
   a_alarm_set: assert property (p_alarm_set) else $error("alarm flag missed");

   property p_alarm_clr;
      wr_alm && !s_q.soft_reset_bit && !(sec_inc && (s_q.seconds == s_q.alarm)) |=> !s_q.alarm_flag;
   endproperty
   a_alarm_clr: assert property (p_alarm_clr) else $error("alarm flag kept");

   property p_tof_set;
      sec_inc && (s_q.seconds == `TKS_SEC_MAX) |=> s_q.overflow_flag && (s_q.seconds == 32'h00000000);
   endproperty
   a_tof_set: assert property (p_tof_set) else $error("overflow missed");

   property p_hidden_read;
      s_hidden_read |=> pready && (prdata == 32'h00000000);
   endproperty
   a_hidden_read: assert property (p_hidden_read) else $error("counter not hidden");

   property p_frozen;
      (s_q.time_invalid_flag || s_q.overflow_flag) && !wr_pre && !s_q.soft_reset_bit |=> $stable(s_q.pre);
   endproperty
   a_frozen: assert property (p_frozen) else $error("prescaler moved");

   property p_flag_clear;
      s_sec_load |=> !s_q.time_invalid_flag && !s_q.overflow_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared");

   property p_lrl_sticky;
      !s_q.lock_register_lock && !s_q.soft_reset_bit |=> !s_q.lock_register_lock;
   endproperty
   a_lrl_sticky: assert property (p_lrl_sticky) else $error("lock lock reopened");

   property p_srl_gate;
      wr_stat && !s_q.status_register_lock && !s_q.um && !s_q.soft_reset_bit |=> $stable(s_q.counter_enable_bit);
   endproperty
   a_srl_gate: assert property (p_srl_gate) else $error("locked status written");

   property p_crl_sticky;
      !s_q.control_register_lock |=> !s_q.control_register_lock;
   endproperty
   a_crl_sticky: assert property (p_crl_sticky) else $error("control lock reopened");

   property p_tcl_gate;
      wr_comp && !s_q.compensation_register_lock && !s_q.soft_reset_bit |=> $stable(s_q.comp);
   endproperty
   a_tcl_gate: assert property (p_tcl_gate) else $error("locked comp written");

   property p_lock_read;
      s_lock_read |=> (prdata[31:8] == 24'h000000) && prdata[7] && (prdata[2:0] == 3'h7);
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("lock fixed bits wrong");

   property p_um_write;
      wr_stat && !s_q.status_register_lock && s_q.um && !s_q.counter_enable_bit && !s_q.soft_reset_bit
         |=> s_q.counter_enable_bit == $past(pwdata[`TKS_SR_TCE]);
   endproperty
   a_um_write: assert property (p_um_write) else $error("update mode write lost");

   property p_step;
      step |=> s_q.pre == $past(pre_next);
   endproperty
   a_step: assert property (p_step) else $error("prescaler did not step");

endmodule

// ==== logic/tks_osc_sync.sv ====
// ****************************************************************
// Brings the 32.768 kHz time base into pclk and marks its rising edges.
// ****************************************************************
module tks_osc_sync (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Time base pin, asynchronous to pclk.
   input wire logic osc_clk,
   // Tick towards the core.
   tks_tick_if.src tick_port
);

   tks_pkg::tks_sync_s s_q;  // Registered state.
   tks_pkg::tks_sync_s s_d;  // Next state.

   // Two stages settle the pin; only the second is compared.
   always_comb begin
      s_d = s_q;
      s_d.meta = osc_clk;
      s_d.sync = s_q.meta;
      s_d.last = s_q.sync;
      s_d.tick = s_q.sync & ~s_q.last;
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_port.tick = s_q.tick;

endmodule

// ==== logic/tks_pkg.sv ====
// ****************************************************************
// Types shared by the timekeeper modules.
// ****************************************************************
package tks_pkg;

   // Complete state of the status and lock block.
   typedef struct packed {
      logic soft_reset_bit;             // Soft reset bit, held until software clears it.
      logic um;              // Update mode bit.
      logic counter_enable_bit;             // Counter enable bit.
      logic alarm_flag;             // Alarm flag.
      logic overflow_flag;             // Overflow flag.
      logic time_invalid_flag;             // Time invalid flag.
      logic lock_register_lock;             // Lock register lock.
      logic status_register_lock;             // Status register lock.
      logic control_register_lock;             // Control register lock.
      logic compensation_register_lock;             // Compensation register lock.
      logic [31:0] seconds;  // Seconds counter.
      logic [15:0] pre;      // Prescaler counter.
      logic [31:0] alarm;    // Alarm compare value.
      logic [31:0] comp;     // Compensation register contents.
      logic [31:0] prdata;   // Registered read data.
      logic pready;          // Registered ready.
      logic pslverr;         // Registered error answer, always low.
   } tks_main_s;

   // State of the time base synchroniser.
   typedef struct packed {
      logic meta;  // First synchroniser stage.
      logic sync;  // Second synchroniser stage.
      logic last;  // Previous synchronised level.
      logic tick;  // One-cycle pulse per time base rising edge.
   } tks_sync_s;

endpackage

// ==== logic/tks_tick_if.sv ====
// ****************************************************************
// Time base tick carried from the synchroniser to the core.
// ****************************************************************
interface tks_tick_if;
   logic tick;  // One pclk cycle per rising edge of the time base.
   modport src (output tick);
   modport dst (input tick);
endinterface

// ==== test/tb_top.sv ====
`include "tks_consts.svh"

// ****************************************************************
// Self-checking bench for the status, enable and lock logic.
// ****************************************************************
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // APB, time base and reset stimulus.
   logic pclk, presetn, psel, penable, pwrite, osc_clk;
   logic [`TKS_ADDR_W-1:0] paddr;
   logic [31:0] pwdata;
   // Answers of the design.
   logic [31:0] prdata;
   logic pready, pslverr;
   // Expected read data, oldest first.
   logic [31:0] exp_q[$];
   // Random state and picked values.
   logic [31:0] rs, sv, cv;
   int failures, n_checks;

   // The block under test.
   tks_core dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .osc_clk(osc_clk)
   );

   // The 50 MHz bus clock.
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ****************************************************************
   // Helpers.
   // ****************************************************************
   // Xorshift generator for data words.
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   // Compares one value and counts it.
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // One APB transfer, held until pready is seen high.
   task automatic xfer(input logic w, input logic [`TKS_ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) check({31'h0, pready}, 32'h00000001);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Register write.
   task automatic wr(input logic [`TKS_ADDR_W-1:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   // Register read; the expected word is noted for the monitor.
   task automatic rd(input logic [`TKS_ADDR_W-1:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h00000000);
   endtask

   // Rising edges on the time base, each well apart in pclk.
   task automatic ticks(input int n);
      repeat (n) begin
         osc_clk <= 1'b1;
         repeat (5) @(posedge pclk);
         osc_clk <= 1'b0;
         repeat (5) @(posedge pclk);
      end
   endtask

   // Monitor: checks pslverr on every completed transfer and compares each read with the oldest note.
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         check({31'h0, pslverr}, 32'h00000000);
         if (pwrite === 1'b0) begin
            if (exp_q.size() == 0) check(32'h00000001, 32'h00000000);
            else check(prdata, exp_q.pop_front());
         end
      end
   end

   // Watchdog that cuts a hang short.
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      final_report();
   end

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      rs = 32'h00000006;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h00000000;
      osc_clk = 1'b0;
      failures = 0;
      n_checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values.
      rd(`TKS_OFF_STAT, 32'h00000001);
      rd(`TKS_OFF_LOCK, 32'h000000FF);
      rd(`TKS_OFF_CTRL, 32'h00000000);
      rd(`TKS_OFF_SEC, 32'h00000000);
      $display("test reset done");
      // Counter writes, freezing, counting and the alarm.
      sv = xs() & 32'h7FFFFFFF;
      wr(`TKS_OFF_PRE, 32'h00007FFE);
      rd(`TKS_OFF_PRE, 32'h00000000);
      wr(`TKS_OFF_SEC, sv);
      rd(`TKS_OFF_STAT, 32'h00000000);
      ticks(3);
      rd(`TKS_OFF_PRE, 32'h00007FFE);
      wr(`TKS_OFF_ALM, sv);
      wr(`TKS_OFF_STAT, 32'h00000010);
      wr(`TKS_OFF_SEC, ~sv);
      wr(`TKS_OFF_PRE, 32'h00000000);
      rd(`TKS_OFF_SEC, sv);
      ticks(2);
      rd(`TKS_OFF_PRE, 32'h00008000);
      rd(`TKS_OFF_SEC, sv + 32'h1);
      rd(`TKS_OFF_STAT, 32'h00000014);
      wr(`TKS_OFF_ALM, xs());
      rd(`TKS_OFF_STAT, 32'h00000010);
      $display("test counting done");
      // Overflow sets the flag, zeroes reads and freezes counting.
      wr(`TKS_OFF_STAT, 32'h00000000);
      wr(`TKS_OFF_PRE, 32'h00007FFF);
      wr(`TKS_OFF_SEC, 32'hFFFFFFFF);
      wr(`TKS_OFF_STAT, 32'h00000010);
      ticks(1);
      rd(`TKS_OFF_STAT, 32'h00000012);
      rd(`TKS_OFF_SEC, 32'h00000000);
      ticks(2);
      rd(`TKS_OFF_PRE, 32'h00000000);
      wr(`TKS_OFF_STAT, 32'h00000000);
      wr(`TKS_OFF_SEC, sv);
      rd(`TKS_OFF_STAT, 32'h00000000);
      rd(`TKS_OFF_PRE, 32'h00008000);
      $display("test overflow done");
      // Compensation and status locks, with update mode.
      cv = xs();
      wr(`TKS_OFF_COMP, cv);
      wr(`TKS_OFF_LOCK, 32'hFFFFFFF7);
      rd(`TKS_OFF_LOCK, 32'h000000F7);
      wr(`TKS_OFF_COMP, ~cv);
      rd(`TKS_OFF_COMP, cv);
      wr(`TKS_OFF_LOCK, 32'h00000050);
      wr(`TKS_OFF_STAT, 32'h00000010);
      rd(`TKS_OFF_STAT, 32'h00000000);
      wr(`TKS_OFF_CTRL, 32'h00000008);
      wr(`TKS_OFF_STAT, 32'h00000010);
      rd(`TKS_OFF_STAT, 32'h00000010);
      wr(`TKS_OFF_STAT, 32'h00000000);
      rd(`TKS_OFF_STAT, 32'h00000010);
      // Lock register lock.
      wr(`TKS_OFF_LOCK, 32'h00000010);
      wr(`TKS_OFF_LOCK, 32'h00000000);
      rd(`TKS_OFF_LOCK, 32'h00000097);
      $display("test locks done");
      // Soft reset holds itself and restores the rest but the control lock.
      wr(`TKS_OFF_ALM, cv);
      wr(`TKS_OFF_CTRL, 32'h00000009);
      rd(`TKS_OFF_CTRL, 32'h00000001);
      rd(`TKS_OFF_LOCK, 32'h000000FF);
      rd(`TKS_OFF_ALM, 32'h00000000);
      rd(`TKS_OFF_COMP, 32'h00000000);
      wr(`TKS_OFF_CTRL, 32'h00000000);
      rd(`TKS_OFF_CTRL, 32'h00000000);
      rd(`TKS_OFF_STAT, 32'h00000001);
      // Control lock, an unmapped read, then a power-on reset.
      wr(`TKS_OFF_LOCK, 32'h000000EF);
      wr(`TKS_OFF_CTRL, 32'h00000008);
      rd(`TKS_OFF_CTRL, 32'h00000000);
      rd(12'h020, 32'h00000000);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(`TKS_OFF_LOCK, 32'h000000FF);
      $display("test soft reset done");
      repeat (4) @(posedge pclk);
      check(32'(exp_q.size()), 32'h00000000);
      final_report();
   end
endmodule
